// ---- rtl/phy_id_pkg.sv ----
// Constants and carrier types for the paged identification and vendor
// control registers of the physical layer.
// Assumes a single 100 MHz device clock and 8-bit paged register access.
package phy_id_pkg;

	// Page selector values written into the base page-select field.
	localparam logic [2:0] PAGE_IDENT  = 3'h1;
	localparam logic [2:0] PAGE_VENDOR = 3'h7;

	// Paged register offsets, shared by both pages.
	localparam logic [3:0] OFS_COMPLIANCE      = 4'h8;
	localparam logic [3:0] OFS_ID_RESERVED     = 4'h9;
	localparam logic [3:0] OFS_MAKER_OUI_HIGH  = 4'ha;
	localparam logic [3:0] OFS_MAKER_OUI_MID   = 4'hb;
	localparam logic [3:0] OFS_MAKER_OUI_LOW   = 4'hc;
	localparam logic [3:0] OFS_PART_IDENT_HIGH = 4'hd;
	localparam logic [3:0] OFS_PART_IDENT_MID  = 4'he;
	localparam logic [3:0] OFS_PART_IDENT_LOW  = 4'hf;
	localparam logic [3:0] OFS_SOFT_RESET_CTRL = 4'he;

	// Bit 0 in the register drawings is the most significant data bit.
	localparam int SOFT_HARD_RESET_BIT = 7;

	// Fixed read-only contents and reset values.
	localparam logic [7:0] COMPLIANCE_LEVEL  = 8'h02;
	localparam logic [2:0] POWER_CLASS_RESET = 3'h0;

	// Self-ID power field: big-endian bits 21..23 of a 32-bit quadlet.
	localparam int SELFID_PWR_LSB = 8;

	// Cycles the strap synchroniser needs before its output is valid.
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

	// Power-class encodings.
	localparam logic [2:0] PWR_NONE         = 3'h0;
	localparam logic [2:0] PWR_SELF_15W     = 3'h1;
	localparam logic [2:0] PWR_SELF_30W     = 3'h2;
	localparam logic [2:0] PWR_SELF_45W     = 3'h3;
	localparam logic [2:0] PWR_BUS_3W_LINK  = 3'h4;
	localparam logic [2:0] PWR_RESERVED     = 3'h5;
	localparam logic [2:0] PWR_BUS_3W_PLUS3 = 3'h6;
	localparam logic [2:0] PWR_BUS_3W_PLUS7 = 3'h7;

	// One paged register request from the link-layer controller.
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [3:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// The answer to a request, one cycle after it is taken.
	typedef struct packed {
		logic       ack;
		logic [7:0] rdata;
	} reg_rsp_t;

endpackage

// ---- rtl/phy_id_page_and_power_class.sv ----
// Paged identification and vendor control registers, plus the strapped
// power class that is reported in every transmitted self-ID packet.
// Assumes the base register logic supplies the page selector and the
// power-class writes to register 4 on the same clock.
module phy_id_page_and_power_class #(
	parameter logic [23:0] MAKER_OUI  = 24'h123456, // Arbitrary value.
	parameter logic [23:0] PART_IDENT = 24'habcdef  // Arbitrary value.
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire phy_id_pkg::reg_req_t  reg_req,
	output phy_id_pkg::reg_rsp_t       reg_rsp,
	input  wire logic [2:0]            page_select,
	input  wire logic                  pwr_class_wr,
	input  wire logic [2:0]            pwr_class_wdata,
	input  wire logic                  strap_mode_en,
	input  wire logic                  power_class_strap_a,
	input  wire logic                  power_class_strap_b,
	input  wire logic                  power_class_strap_c,
	input  wire logic [31:0]           selfid_in,
	output logic [31:0]                selfid_out,
	output logic [2:0]                 power_class,
	output logic                       soft_hard_reset
);

	logic [2:0] strap_meta_q;
	logic [2:0] strap_sync_q;
	logic [1:0] settle_q;
	logic       load_pending_q;
	logic [2:0] pwr_q;
	logic       soft_rst_q;
	logic       ack_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       upper_hit;
	logic       soft_rst_hit;

	// Upper address half is paged; lower half belongs to the base page.
	assign upper_hit = reg_req.valid && reg_req.addr[3];

	assign soft_rst_hit = upper_hit && reg_req.write &&
		(page_select == phy_id_pkg::PAGE_VENDOR) &&
		(reg_req.addr == phy_id_pkg::OFS_SOFT_RESET_CTRL) &&
		reg_req.wdata[phy_id_pkg::SOFT_HARD_RESET_BIT];

	// Straps are asynchronous pins, so they pass two flip-flops first.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_meta_q <= 3'h0;
			strap_sync_q <= 3'h0;
		end else begin
			strap_meta_q <= {power_class_strap_a, power_class_strap_b,
				power_class_strap_c};
			strap_sync_q <= strap_meta_q;
		end
	end

	// The load waits for the synchroniser to fill, both after the pin
	// reset and after a software reset, so stale strap levels are never
	// taken.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_q       <= 2'h0;
			load_pending_q <= 1'b1;
		end else if (soft_rst_q) begin
			settle_q       <= 2'h0;
			load_pending_q <= 1'b1;
		end else if (pwr_class_wr) begin
			// A software value must never be undone by a late strap load.
			load_pending_q <= 1'b0;
		end else if (load_pending_q) begin
			if (settle_q == phy_id_pkg::STRAP_SETTLE_CYCLES) begin
				load_pending_q <= 1'b0;
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	// A register 4 write overrides the strap default; a software reset
	// returns the field to its reset value before the straps reload.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q <= phy_id_pkg::POWER_CLASS_RESET;
		end else if (soft_rst_q) begin
			pwr_q <= phy_id_pkg::POWER_CLASS_RESET;
		end else if (pwr_class_wr) begin
			pwr_q <= pwr_class_wdata;
		end else if (load_pending_q && strap_mode_en &&
			(settle_q == phy_id_pkg::STRAP_SETTLE_CYCLES)) begin
			pwr_q <= strap_sync_q;
		end
	end

	// Encodings are passed through unaltered, reserved 101 included.
	assign power_class = pwr_q;

	always_comb begin
		selfid_out = selfid_in;
		selfid_out[phy_id_pkg::SELFID_PWR_LSB +: 3] = pwr_q;
	end

	// The bit itself is never stored: only a one-cycle pulse is made,
	// so a write cannot leave the device held in reset.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= soft_rst_hit && !soft_rst_q;
		end
	end

	assign soft_hard_reset = soft_rst_q;

	// Read data decode.
	always_comb begin
		rdata_d = 8'h00;
		if (upper_hit && !reg_req.write) begin
			unique case (page_select)
				phy_id_pkg::PAGE_IDENT: begin
					unique case (reg_req.addr)
						phy_id_pkg::OFS_COMPLIANCE:
							rdata_d = phy_id_pkg::COMPLIANCE_LEVEL;
						phy_id_pkg::OFS_MAKER_OUI_HIGH:
							rdata_d = MAKER_OUI[23:16];
						phy_id_pkg::OFS_MAKER_OUI_MID:
							rdata_d = MAKER_OUI[15:8];
						phy_id_pkg::OFS_MAKER_OUI_LOW:
							rdata_d = MAKER_OUI[7:0];
						phy_id_pkg::OFS_PART_IDENT_HIGH:
							rdata_d = PART_IDENT[23:16];
						phy_id_pkg::OFS_PART_IDENT_MID:
							rdata_d = PART_IDENT[15:8];
						phy_id_pkg::OFS_PART_IDENT_LOW:
							rdata_d = PART_IDENT[7:0];
						default:
							rdata_d = 8'h00;
					endcase
				end
				// Vendor page: soft reset reads zero, reserved and test
				// bits read zero as well.
				phy_id_pkg::PAGE_VENDOR: rdata_d = 8'h00;
				default:                 rdata_d = 8'h00;
			endcase
		end
	end

	// Every request is answered one cycle later, writes included.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q   <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			ack_q   <= reg_req.valid;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rsp.ack   = ack_q;
	assign reg_rsp.rdata = rdata_q;

	a_compliance_read: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_IDENT &&
		reg_req.addr == phy_id_pkg::OFS_COMPLIANCE
		|=> reg_rsp.ack && reg_rsp.rdata == 8'h02)
		else $error("compliance level read wrong");

	a_id_rsvd_zero: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_IDENT && reg_req.addr == 4'h9
		|=> reg_rsp.rdata == 8'h00)
		else $error("identification reserved byte not zero");

	a_maker_msb_read: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_IDENT && reg_req.addr == 4'ha
		|=> reg_rsp.rdata == MAKER_OUI[23:16])
		else $error("maker identifier high byte wrong");

	a_maker_mid_read: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_IDENT && reg_req.addr == 4'hb
		|=> reg_rsp.rdata == MAKER_OUI[15:8])
		else $error("maker identifier middle byte wrong");

	a_maker_low_read: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_IDENT && reg_req.addr == 4'hc
		|=> reg_rsp.rdata == MAKER_OUI[7:0])
		else $error("maker identifier low byte wrong");

	a_part_high_read: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_IDENT && reg_req.addr == 4'hd
		|=> reg_rsp.rdata == PART_IDENT[23:16])
		else $error("part identifier high byte wrong");

	a_part_mid_read: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_IDENT && reg_req.addr == 4'he
		|=> reg_rsp.rdata == PART_IDENT[15:8])
		else $error("part identifier middle byte wrong");

	a_part_low_read: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_IDENT && reg_req.addr == 4'hf
		|=> reg_rsp.rdata == PART_IDENT[7:0])
		else $error("part identifier low byte wrong");

	a_vendor_reads_zero: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		page_select == phy_id_pkg::PAGE_VENDOR
		|=> reg_rsp.rdata == 8'h00)
		else $error("vendor page read not zero");

	a_other_page_zero: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && !reg_req.write &&
		(!reg_req.addr[3] || (page_select != phy_id_pkg::PAGE_IDENT))
		|=> reg_rsp.rdata == 8'h00)
		else $error("unmapped read not zero");

	a_write_reads_zero: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && reg_req.write |=> reg_rsp.rdata == 8'h00)
		else $error("write answered with data");

	a_ack_follows: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid |=> reg_rsp.ack)
		else $error("request not acknowledged");

	a_ack_drops: assert property (@(posedge clk)
		disable iff (!rst_n)
		!reg_req.valid |=> !reg_rsp.ack)
		else $error("acknowledge without request");

	a_soft_rst_pulse: assert property (@(posedge clk)
		disable iff (!rst_n)
		soft_rst_hit && !soft_hard_reset
		|=> soft_hard_reset ##1 !soft_hard_reset)
		else $error("soft reset pulse not single");

	a_soft_rst_bit: assert property (@(posedge clk)
		disable iff (!rst_n)
		reg_req.valid && reg_req.write &&
		page_select == phy_id_pkg::PAGE_VENDOR &&
		reg_req.addr == 4'he && !reg_req.wdata[7]
		|=> !soft_hard_reset)
		else $error("soft reset without its bit");

	a_soft_rst_cause: assert property (@(posedge clk)
		disable iff (!rst_n)
		soft_hard_reset |-> $past(soft_rst_hit))
		else $error("soft reset without write");

	a_soft_rst_reload: assert property (@(posedge clk)
		disable iff (!rst_n)
		soft_hard_reset |=> power_class == 3'h0 && load_pending_q)
		else $error("soft reset did not restore power class");

	a_reg4_override: assert property (@(posedge clk)
		disable iff (!rst_n)
		pwr_class_wr && !soft_hard_reset
		|=> power_class == $past(pwr_class_wdata))
		else $error("power class write not taken");

	a_wr_cancels_load: assert property (@(posedge clk)
		disable iff (!rst_n)
		pwr_class_wr && !soft_hard_reset |=> !load_pending_q)
		else $error("strap load still pending after write");

	a_strap_load: assert property (@(posedge clk)
		disable iff (!rst_n)
		load_pending_q && strap_mode_en && !pwr_class_wr && !soft_rst_q &&
		settle_q == 2'h2 |=> power_class == $past(strap_sync_q))
		else $error("strap default not loaded");

	a_strap_off_hold: assert property (@(posedge clk)
		disable iff (!rst_n)
		!strap_mode_en && !pwr_class_wr && !soft_hard_reset
		|=> $stable(power_class))
		else $error("power class moved without a cause");

	a_settle_bound: assert property (@(posedge clk)
		disable iff (!rst_n)
		settle_q <= phy_id_pkg::STRAP_SETTLE_CYCLES)
		else $error("strap settle counter overran");

	a_selfid_field: assert property (@(posedge clk)
		disable iff (!rst_n)
		selfid_out[10:8] == power_class &&
		selfid_out[31:11] == selfid_in[31:11] &&
		selfid_out[7:0] == selfid_in[7:0])
		else $error("self-ID power field wrong");

endmodule // phy_id_page_and_power_class

// ---- verification/link_ctrl_model.sv ----
// Link-layer controller model that issues paged register requests.
// Assumes requests are launched on the falling edge of clk.
module link_ctrl_model (
	input  wire logic           clk,
	output phy_id_pkg::reg_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	// One-cycle request pulse; idle fields are inverted so that stale
	// bytes are never mistaken for a fresh request.
	task automatic access(input logic wr, input logic [3:0] a,
			input logic [7:0] d);
		@(negedge clk);
		req = '{valid: 1'b1, write: wr, addr: a, wdata: d};
		@(negedge clk);
		req = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
	endtask
endmodule // link_ctrl_model

// ---- verification/testbench.sv ----
// Self-checking bench for the paged identification and power-class block.
// Assumes the link controller model drives every register request.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// Arbitrary identifier values, not those of any real part.
	localparam logic [23:0] OUI  = 24'h5a3c91;
	localparam logic [23:0] PART = 24'h7e24b8;
	localparam logic [63:0] ID_PAGE = {8'h02, 8'h00, OUI, PART};

	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	phy_id_pkg::reg_req_t req;
	phy_id_pkg::reg_rsp_t rsp;
	logic [2:0]           page, pc_wdata, pc, straps;
	logic                 pc_wr, strap_en, hard_rst;
	logic [31:0]          sid_in, sid_out;
	logic [7:0]           exp_q[$];
	int                   failures = 0, checks = 0, pulses = 0, seed = 91;

	always #5 clk = ~clk;

	phy_id_page_and_power_class #(.MAKER_OUI(OUI), .PART_IDENT(PART)) DUT (
		.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rsp(rsp),
		.page_select(page), .pwr_class_wr(pc_wr),
		.pwr_class_wdata(pc_wdata), .strap_mode_en(strap_en),
		.power_class_strap_a(straps[2]), .power_class_strap_b(straps[1]),
		.power_class_strap_c(straps[0]), .selfid_in(sid_in),
		.selfid_out(sid_out), .power_class(pc), .soft_hard_reset(hard_rst));

	link_ctrl_model LINK (.clk(clk), .req(req));

	task automatic check(input string n, input logic [31:0] e,
			input logic [31:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Read answers: the data byte that stands with the acknowledge.
	task automatic check_rd(input logic [7:0] e);
		check("rdata", {24'h0, e}, {24'h0, rsp.rdata});
	endtask

	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		LINK.access(1'b0, a, 8'h00);
	endtask

	// Writes answer with zero data.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		exp_q.push_back(8'h00);
		LINK.access(1'b1, a, d);
	endtask

	task automatic check_pc(input logic [2:0] e);
		sid_in = $random(seed);
		#1;
		check("power_class", {29'h0, e}, {29'h0, pc});
		check("selfid", {sid_in[31:11], e, sid_in[7:0]}, sid_out);
	endtask

	always @(posedge clk) begin
		if (hard_rst === 1'b1)
			pulses++;
		if (rsp.ack === 1'b1) begin
			if (exp_q.size() == 0)
				check("spare ack", 32'h0, 32'h1);
			else
				check_rd(exp_q.pop_front());
		end
	end

	initial begin
		#20000;
		failures++;
		finish_test();
	end

	initial begin
		pc_wr = 1'b0;
		pc_wdata = 3'h0;
		page = 3'h0;
		sid_in = 32'h0;
		strap_en = 1'b1;
		straps = 3'($random(seed)) | 3'h2;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		check_pc(straps);
		page = 3'h1;
		for (int i = 8; i < 16; i++)
			rd(4'(i), ID_PAGE[127 - 8 * i -: 8]);
		page = 3'h0;
		rd(4'h8, 8'h00);
		page = 3'h7;
		wr(4'h9, 8'h00);
		for (int i = 8; i < 16; i++)
			rd(4'(i), 8'h00);
		for (int v = 0; v < 8; v++) begin
			@(negedge clk);
			pc_wr = 1'b1;
			pc_wdata = 3'(v);
			@(negedge clk);
			pc_wr = 1'b0;
			check_pc(3'(v));
		end
		wr(4'he, 8'h00);
		wr(4'he, 8'h80);
		@(negedge clk);
		check("pc after soft reset", 32'h0, {29'h0, pc});
		repeat (6) @(negedge clk);
		check("reset pulses", 32'h1, pulses);
		check_pc(straps);
		rd(4'he, 8'h00);
		// Let the answer land before reset wipes the acknowledge.
		repeat (2) @(negedge clk);
		strap_en = 1'b0;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (6) @(negedge clk);
		check_pc(3'h0);
		// A write inside the strap settling window must stand.
		strap_en = 1'b1;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		pc_wr = 1'b1;
		pc_wdata = ~straps;
		@(negedge clk);
		pc_wr = 1'b0;
		repeat (4) @(negedge clk);
		check_pc(~straps);
		check("queue left", 32'h0, exp_q.size());
		finish_test();
	end
endmodule // testbench
